// >>> ccl_pkg.sv
// shared constants and types for the core config and memory lock bank
package ccl_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CCL_OFF_CORE_REQ = 8'h80;
    localparam logic [7:0] CCL_OFF_LOCK_STATE = 8'h88;
    localparam logic [7:0] CCL_OFF_ACCESS_LOCK = 8'h8C;
    localparam logic [7:0] CCL_OFF_CFG_LOCK_CTRL = 8'h90;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CCL_REQ_LOCK_BIT = 16;
    localparam int CCL_THREAD_DIS_BIT = 8;
    localparam int CCL_CORE_CNT_LSB = 0;
    localparam int CCL_CORE_CNT_W = 2;
    localparam int CCL_ST_REMOTE_BIT = 9;
    localparam int CCL_ST_LOCAL_BIT = 8;
    localparam int CCL_ST_USER_BIT = 1;
    localparam int CCL_ST_CFG_BIT = 0;
    localparam int CCL_CTL_LOCK_BIT = 0;
    localparam int CCL_CTL_UNLOCK_BIT = 1;
    localparam int CCL_AL_CFG_SET_BIT = 0;
    localparam int CCL_AL_LOCAL_SET_BIT = 8;
    localparam int CCL_AL_REMOTE_SET_BIT = 9;
    localparam int CCL_AL_LOCAL_CLR_BIT = 24;
    localparam int CCL_AL_REMOTE_CLR_BIT = 25;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CCL_CORE_REQ_RST = 32'h0000_0000;
    localparam logic [31:0] CCL_READ_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CCL_CORES_MAX = 2'h0,
        CCL_CORES_ONE = 2'h1,
        CCL_CORES_TWO = 2'h2
    } ccl_core_cnt_t;

    typedef enum logic {
        CCL_BUS_IDLE = 1'b0,
        CCL_BUS_DONE = 1'b1
    } ccl_bus_state_t;

    typedef enum logic [1:0] {
        CCL_CLS_GENERAL = 2'h0,
        CCL_CLS_THERMAL = 2'h1,
        CCL_CLS_LEGACY = 2'h2,
        CCL_CLS_SYSMEM = 2'h3
    } ccl_cfg_class_t;

endpackage : ccl_pkg

// >>> ccl_gate_if.sv
// lock levels passed from the register bank to the access gate
`timescale 1ns/1ps
interface ccl_gate_if;
    logic cfg_locked;
    logic mem_local_lock;
    logic mem_remote_lock;
    logic mc_enabled;

    modport ctrl (
        output cfg_locked,
        output mem_local_lock,
        output mem_remote_lock,
        output mc_enabled
    );

    modport gate (
        input cfg_locked,
        input mem_local_lock,
        input mem_remote_lock,
        input mc_enabled
    );
endinterface : ccl_gate_if

// >>> ccl_sync.sv
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module ccl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] stable
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            stable <= '0;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    stable[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : ccl_sync

// >>> ccl_access_gate.sv
// gates controller config writes and memory requests by the current locks
`timescale 1ns/1ps
module ccl_access_gate (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    ccl_gate_if.gate locks,
    input wire logic cfg_wr_req,
    input wire logic [1:0] cfg_wr_class,
    input wire logic mem_req,
    input wire logic mem_req_remote,
    output logic cfg_wr_grant,
    output logic cfg_wr_reject,
    output logic mem_req_accept,
    output logic mem_req_abort
);
    logic exempt;
    logic abort_now;

    // R11: exempt classes
    assign exempt = (cfg_wr_class != ccl_pkg::CCL_CLS_GENERAL);
    // R6: remote abort / R7: local abort
    assign abort_now = mem_req_remote ? locks.mem_remote_lock : locks.mem_local_lock;

    // ----------------------------------------------------------------
    // config write gating
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_wr_grant <= 1'b0;
            cfg_wr_reject <= 1'b0;
        end else if (ce) begin
            // R10: lockdown rejects writes
            cfg_wr_grant <= cfg_wr_req && (exempt || !locks.cfg_locked);
            cfg_wr_reject <= cfg_wr_req && !exempt && locks.cfg_locked;
        end
    end

    // ----------------------------------------------------------------
    // memory request gating
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_req_accept <= 1'b0;
            mem_req_abort <= 1'b0;
        end else if (ce) begin
            // R12: no requests before lock
            mem_req_accept <= mem_req && locks.mc_enabled && !abort_now;
            mem_req_abort <= mem_req && locks.mc_enabled && abort_now;
        end
    end

    // R10: general write refused
    a_cfg_reject: assert property (@(posedge clk) disable iff (reset) // R10
        ce && cfg_wr_req && locks.cfg_locked && !exempt |=> cfg_wr_reject && !cfg_wr_grant)
        else $error("locked config write not rejected");
    // R11: exempt write passes
    a_exempt_pass: assert property (@(posedge clk) disable iff (reset) // R11
        ce && cfg_wr_req && exempt |=> cfg_wr_grant && !cfg_wr_reject)
        else $error("exempt config write not granted");
    // R6: remote access aborted
    a_remote_abort: assert property (@(posedge clk) disable iff (reset) // R6
        ce && mem_req && mem_req_remote && locks.mem_remote_lock && locks.mc_enabled
        |=> mem_req_abort && !mem_req_accept)
        else $error("remote access not aborted");
    // R7: local access aborted
    a_local_abort: assert property (@(posedge clk) disable iff (reset) // R7
        ce && mem_req && !mem_req_remote && locks.mem_local_lock && locks.mc_enabled
        |=> mem_req_abort && !mem_req_accept)
        else $error("local access not aborted");
    // R12: no accept before lock
    a_mc_hold_off: assert property (@(posedge clk) disable iff (reset) // R12
        ce && !locks.mc_enabled |=> !mem_req_accept && !mem_req_abort)
        else $error("memory request answered before controller lock");
endmodule : ccl_access_gate

// >>> ccl_top.sv
// core count request and memory lock register bank with avalon-mm slave
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// R1: requested cores and threading apply at processor reset
// R2: request lock bit sets only, blocks writes
// R3: thread disable leaves one thread per core
// R4: core count 00 max, 01 one, 10 two
// R5: firmware must not exceed real core count
// R6: remote lock aborts other agents' memory access
// R7: local lock aborts this processor's memory access
// R8: memory locks clear only in authenticated mode
// R9: status bit 1 mirrors user config lock
// R10: status bit 0 rejects controller config writes
// R11: thermal, legacy and system memory registers exempt
// R12: controller accepts requests only after lock written
// R13: writing lock bit blocks config writes
// R14: unlock 1 with lock 0 reopens writes
// R15: unlock leaves other lock types until reset
// R16: lock control reads zero, zero writes inert
// ----------------------------------------------------------------
module ccl_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic proc_reset_pin,
    input wire logic auth_mode_pin,
    input wire logic cfg_wr_req,
    input wire logic [1:0] cfg_wr_class,
    input wire logic mem_req,
    input wire logic mem_req_remote,
    output logic cfg_wr_grant,
    output logic cfg_wr_reject,
    output logic mem_req_accept,
    output logic mem_req_abort,
    output logic [1:0] active_core_count,
    output logic active_thread_disable,
    output logic mc_accepting
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic wr_one(input logic [31:0] d, input logic [31:0] m,
                                    input int pos);
        return d[pos] && m[pos];
    endfunction : wr_one

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ccl_pkg::ccl_bus_state_t bus_state_reg;
    logic [31:0] wmask;
    logic commit_wr;
    logic commit_rd;
    logic wr_core;
    logic wr_access;
    logic wr_ctrl;
    logic [31:0] rd_next;
    logic [1:0] core_cnt_reg;
    logic thread_dis_reg;
    logic req_lock_reg;
    logic cfg_lock_reg;
    logic user_lock_reg;
    logic local_lock_reg;
    logic remote_lock_reg;
    logic [1:0] pins_stable;
    logic auth_mode;
    logic proc_rst;
    logic proc_rst_prev_reg;
    logic proc_rst_edge;
    logic ctl_lock;
    logic ctl_unlock;
    logic local_clr_ok;
    logic remote_clr_ok;

    ccl_gate_if locks_if ();

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    ccl_sync #(
        .WIDTH(2)
    ) pin_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .pin({auth_mode_pin, proc_reset_pin}),
        .stable(pins_stable)
    );

    assign proc_rst = pins_stable[0];
    assign auth_mode = pins_stable[1];
    assign proc_rst_edge = proc_rst && !proc_rst_prev_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            proc_rst_prev_reg <= 1'b0;
        end else if (ce) begin
            proc_rst_prev_reg <= proc_rst;
        end
    end

    // ----------------------------------------------------------------
    // avalon-mm slave handshake
    // ----------------------------------------------------------------
    // one wait cycle: request seen, then waitrequest low for one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_state_reg <= ccl_pkg::CCL_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            case (bus_state_reg)
                ccl_pkg::CCL_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= ccl_pkg::CCL_BUS_DONE;
                        avs_waitrequest <= 1'b0;
                    end
                end
                ccl_pkg::CCL_BUS_DONE: begin
                    bus_state_reg <= ccl_pkg::CCL_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state_reg <= ccl_pkg::CCL_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    assign commit_wr = ce && avs_write && (bus_state_reg == ccl_pkg::CCL_BUS_DONE);
    assign commit_rd = ce && avs_read && (bus_state_reg == ccl_pkg::CCL_BUS_DONE);
    assign wmask = lane_mask(avs_byteenable);
    assign wr_core = commit_wr && (avs_address == ccl_pkg::CCL_OFF_CORE_REQ);
    assign wr_access = commit_wr && (avs_address == ccl_pkg::CCL_OFF_ACCESS_LOCK);
    assign wr_ctrl = commit_wr && (avs_address == ccl_pkg::CCL_OFF_CFG_LOCK_CTRL);

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        rd_next = ccl_pkg::CCL_READ_ZERO;
        case (avs_address)
            ccl_pkg::CCL_OFF_CORE_REQ: begin
                rd_next[ccl_pkg::CCL_REQ_LOCK_BIT] = req_lock_reg;
                rd_next[ccl_pkg::CCL_THREAD_DIS_BIT] = thread_dis_reg;
                rd_next[ccl_pkg::CCL_CORE_CNT_LSB +: ccl_pkg::CCL_CORE_CNT_W] = core_cnt_reg;
            end
            ccl_pkg::CCL_OFF_LOCK_STATE: begin
                rd_next[ccl_pkg::CCL_ST_REMOTE_BIT] = remote_lock_reg;
                rd_next[ccl_pkg::CCL_ST_LOCAL_BIT] = local_lock_reg;
                // R9: user lock visible
                rd_next[ccl_pkg::CCL_ST_USER_BIT] = user_lock_reg;
                rd_next[ccl_pkg::CCL_ST_CFG_BIT] = cfg_lock_reg;
            end
            ccl_pkg::CCL_OFF_ACCESS_LOCK: begin
                rd_next[ccl_pkg::CCL_AL_CFG_SET_BIT] = cfg_lock_reg;
                rd_next[ccl_pkg::CCL_AL_LOCAL_SET_BIT] = local_lock_reg;
                rd_next[ccl_pkg::CCL_AL_REMOTE_SET_BIT] = remote_lock_reg;
            end
            // R16: write-only register reads zero
            default: begin
                rd_next = ccl_pkg::CCL_READ_ZERO;
            end
        endcase
    end

    // data latched as waitrequest drops, held through the answer edge
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= ccl_pkg::CCL_READ_ZERO;
        end else if (ce && avs_read && bus_state_reg == ccl_pkg::CCL_BUS_IDLE) begin
            avs_readdata <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // core and thread request
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            core_cnt_reg <= ccl_pkg::CCL_CORE_REQ_RST[ccl_pkg::CCL_CORE_CNT_LSB +: 2];
            thread_dis_reg <= ccl_pkg::CCL_CORE_REQ_RST[ccl_pkg::CCL_THREAD_DIS_BIT];
            req_lock_reg <= ccl_pkg::CCL_CORE_REQ_RST[ccl_pkg::CCL_REQ_LOCK_BIT];
        // R2: locked register ignores writes
        end else if (wr_core && !req_lock_reg) begin
            if (wmask[ccl_pkg::CCL_CORE_CNT_LSB]) begin
                core_cnt_reg <= avs_writedata[ccl_pkg::CCL_CORE_CNT_LSB +: 2];
            end
            if (wmask[ccl_pkg::CCL_THREAD_DIS_BIT]) begin
                thread_dis_reg <= avs_writedata[ccl_pkg::CCL_THREAD_DIS_BIT];
            end
            // R2: lock sets only
            if (wr_one(avs_writedata, wmask, ccl_pkg::CCL_REQ_LOCK_BIT)) begin
                req_lock_reg <= 1'b1;
            end
        end
    end

    // R1: settings take effect on processor reset
    always_ff @(posedge clk) begin
        if (reset) begin
            active_core_count <= ccl_pkg::CCL_CORES_MAX;
            active_thread_disable <= 1'b0;
        end else if (ce && proc_rst_edge) begin
            // R4: count encoding passes through
            active_core_count <= core_cnt_reg;
            // R3: one thread per core
            active_thread_disable <= thread_dis_reg;
        end
    end

    // ----------------------------------------------------------------
    // controller config lock control
    // ----------------------------------------------------------------
    assign ctl_lock = wr_ctrl && wr_one(avs_writedata, wmask, ccl_pkg::CCL_CTL_LOCK_BIT);
    assign ctl_unlock = wr_ctrl && wr_one(avs_writedata, wmask, ccl_pkg::CCL_CTL_UNLOCK_BIT);

    always_ff @(posedge clk) begin
        if (reset) begin
            user_lock_reg <= 1'b0;
        // R13: lock blocks config writes
        end else if (ctl_lock) begin
            user_lock_reg <= 1'b1;
        // R14: unlock with lock written 0
        end else if (ctl_unlock) begin
            user_lock_reg <= 1'b0;
        end
    end

    // R12: controller starts once locked
    always_ff @(posedge clk) begin
        if (reset) begin
            mc_accepting <= 1'b0;
        end else if (ctl_lock) begin
            mc_accepting <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // platform and memory access locks
    // ----------------------------------------------------------------
    // R8: clears only in authenticated mode
    assign local_clr_ok = wr_access && auth_mode &&
        wr_one(avs_writedata, wmask, ccl_pkg::CCL_AL_LOCAL_CLR_BIT);
    assign remote_clr_ok = wr_access && auth_mode &&
        wr_one(avs_writedata, wmask, ccl_pkg::CCL_AL_REMOTE_CLR_BIT);

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_lock_reg <= 1'b0;
        // R15: platform lock held until reset
        end else if (wr_access && wr_one(avs_writedata, wmask, ccl_pkg::CCL_AL_CFG_SET_BIT)) begin
            cfg_lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            local_lock_reg <= 1'b0;
        end else if (wr_access && wr_one(avs_writedata, wmask, ccl_pkg::CCL_AL_LOCAL_SET_BIT)) begin
            local_lock_reg <= 1'b1;
        end else if (local_clr_ok) begin
            local_lock_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            remote_lock_reg <= 1'b0;
        end else if (wr_access && wr_one(avs_writedata, wmask, ccl_pkg::CCL_AL_REMOTE_SET_BIT)) begin
            remote_lock_reg <= 1'b1;
        end else if (remote_clr_ok) begin
            remote_lock_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // access gate
    // ----------------------------------------------------------------
    // R10: either config lock closes writes
    assign locks_if.cfg_locked = cfg_lock_reg || user_lock_reg;
    assign locks_if.mem_local_lock = local_lock_reg;
    assign locks_if.mem_remote_lock = remote_lock_reg;
    assign locks_if.mc_enabled = mc_accepting;

    ccl_access_gate gate (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .locks(locks_if.gate),
        .cfg_wr_req(cfg_wr_req),
        .cfg_wr_class(cfg_wr_class),
        .mem_req(mem_req),
        .mem_req_remote(mem_req_remote),
        .cfg_wr_grant(cfg_wr_grant),
        .cfg_wr_reject(cfg_wr_reject),
        .mem_req_accept(mem_req_accept),
        .mem_req_abort(mem_req_abort)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_ctrl_req;
        avs_read && (avs_address == ccl_pkg::CCL_OFF_CFG_LOCK_CTRL) &&
        (bus_state_reg == ccl_pkg::CCL_BUS_IDLE) && ce;
    endsequence

    sequence s_ctrl_answer;
        !avs_waitrequest && (avs_readdata == ccl_pkg::CCL_READ_ZERO);
    endsequence

    // R16: control reads zero
    a_ctrl_read_zero: assert property (@(posedge clk) disable iff (reset) // R16
        s_ctrl_req |=> s_ctrl_answer)
        else $error("lock control read not zero");
    // R2: locked request frozen
    a_req_frozen: assert property (@(posedge clk) disable iff (reset) // R2
        wr_core && req_lock_reg |=> $stable(core_cnt_reg) && $stable(thread_dis_reg))
        else $error("locked request register changed");
    // R2: lock stays set
    a_req_lock_sticky: assert property (@(posedge clk) disable iff (reset) // R2
        req_lock_reg |=> req_lock_reg)
        else $error("request lock cleared without reset");
    // R1: no change without processor reset
    a_apply_on_reset: assert property (@(posedge clk) disable iff (reset) // R1
        !(ce && proc_rst_edge) |=> $stable(active_core_count) && $stable(active_thread_disable))
        else $error("active settings changed outside processor reset");
    // R8: clear needs authenticated mode
    a_clear_needs_auth: assert property (@(posedge clk) disable iff (reset) // R8
        $fell(local_lock_reg) || $fell(remote_lock_reg) |-> $past(auth_mode))
        else $error("memory lock cleared outside authenticated mode");
    // R14: unlock reopens writes
    a_unlock_reopen: assert property (@(posedge clk) disable iff (reset) // R14
        ctl_unlock && !ctl_lock |=> !user_lock_reg && $stable(cfg_lock_reg))
        else $error("unlock did not reopen or touched another lock");
    // R12: traffic enabled by lock
    a_mc_enable: assert property (@(posedge clk) disable iff (reset) // R12
        ctl_lock |=> mc_accepting ##1 mc_accepting)
        else $error("controller not accepting after lock");
    // R13: lock blocks general writes
    a_lock_blocks: assert property (@(posedge clk) disable iff (reset) // R13
        user_lock_reg && ce && cfg_wr_req && cfg_wr_class == ccl_pkg::CCL_CLS_GENERAL
        |=> cfg_wr_reject)
        else $error("config write allowed after lock");

endmodule : ccl_top

// >>> ccl_top_tb.sv
// self-checking bench for the core request and memory lock bank
`timescale 1ns/1ps
module ccl_top_tb;
    logic clk = 0, reset = 1, ce = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic proc_reset_pin = 0, auth_mode_pin = 0, cfg_wr_req = 0, mem_req = 0, mem_req_remote = 0;
    logic [1:0] cfg_wr_class = 0, active_core_count;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, v;
    logic [3:0] avs_byteenable = 4'hf;
    logic cfg_wr_grant, cfg_wr_reject, mem_req_accept, mem_req_abort;
    logic active_thread_disable, mc_accepting;
    logic [31:0] rq[$];
    logic [1:0] gq[$];
    int err_total = 0, checks_done = 0;
    ccl_top u_ccl_top (.clk(clk), .reset(reset), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .proc_reset_pin(proc_reset_pin),
        .auth_mode_pin(auth_mode_pin), .cfg_wr_req(cfg_wr_req), .cfg_wr_class(cfg_wr_class),
        .mem_req(mem_req), .mem_req_remote(mem_req_remote), .cfg_wr_grant(cfg_wr_grant),
        .cfg_wr_reject(cfg_wr_reject), .mem_req_accept(mem_req_accept),
        .mem_req_abort(mem_req_abort), .active_core_count(active_core_count),
        .active_thread_disable(active_thread_disable), .mc_accepting(mc_accepting));
    always #25 clk = ~clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task final_report;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // avalon access, held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w) rq.push_back(d);
        @(posedge clk);
        avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= w ? d : 32'h0;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 0; avs_read <= 0;
    endtask : bus
    task gate(input logic m, input logic [1:0] c, input logic [1:0] e);
        gq.push_back(e);
        @(posedge clk);
        cfg_wr_req <= !m; mem_req <= m; cfg_wr_class <= c; mem_req_remote <= c[0];
        @(posedge clk);
        cfg_wr_req <= 0; mem_req <= 0;
        repeat (2) @(posedge clk);
    endtask : gate
    task sync_wait;
        repeat (8) @(posedge clk);
    endtask : sync_wait
    // result watchers take the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, rq.pop_front());
        if ((cfg_wr_grant | cfg_wr_reject | mem_req_accept | mem_req_abort) === 1'b1)
            chk({30'h0, cfg_wr_grant | mem_req_accept, cfg_wr_reject | mem_req_abort},
                {30'h0, gq.pop_front()});
    end
    initial begin
        #(50 * 4000);
        err_total++;
        final_report();
    end
    initial begin
        v = $urandom(32'h3b42_6d4a);
        repeat (2) @(posedge clk);
        reset <= 0;
        bus(0, 8'h80, 32'h0000_0000);
        bus(0, 8'h90, 32'h0000_0000);
        bus(0, 8'h44, 32'h0000_0000);
        v = {23'h0, 1'($urandom), 6'h0, 2'($urandom % 3)};
        bus(1, 8'h80, v);
        bus(0, 8'h80, v);
        chk({30'h0, active_core_count}, 32'h0000_0000);
        proc_reset_pin <= 1;
        sync_wait();
        proc_reset_pin <= 0;
        sync_wait();
        chk({30'h0, active_core_count}, {30'h0, v[1:0]});
        chk({31'h0, active_thread_disable}, {31'h0, v[8]});
        bus(1, 8'h80, v | 32'h0001_0000);
        bus(1, 8'h80, 32'h0000_0102);
        bus(0, 8'h80, v | 32'h0001_0000);
        @(posedge clk) mem_req <= 1;
        @(posedge clk) mem_req <= 0;
        @(posedge clk) chk({30'h0, mem_req_accept, mem_req_abort}, 32'h0000_0000);
        bus(1, 8'h90, 32'h0000_0000);
        chk({31'h0, mc_accepting}, 32'h0000_0000);
        bus(1, 8'h90, 32'h0000_0001);
        bus(0, 8'h90, 32'h0000_0000);
        bus(0, 8'h88, 32'h0000_0002);
        chk({31'h0, mc_accepting}, 32'h0000_0001);
        gate(0, 2'h0, 2'b01);
        for (int c = 1; c < 4; c++) gate(0, 2'(c), 2'b10);
        bus(1, 8'h90, 32'h0000_0002);
        gate(0, 2'h0, 2'b10);
        bus(0, 8'h88, 32'h0000_0000);
        bus(1, 8'h8C, 32'h0000_0001);
        bus(0, 8'h88, 32'h0000_0001);
        gate(0, 2'h0, 2'b01);
        bus(1, 8'h90, 32'h0000_0002);
        gate(0, 2'h0, 2'b01);
        gate(1, 2'h0, 2'b10);
        bus(1, 8'h8C, 32'h0000_0300);
        gate(1, 2'h0, 2'b01);
        gate(1, 2'h1, 2'b01);
        bus(1, 8'h8C, 32'h0300_0000);
        bus(0, 8'h88, 32'h0000_0301);
        auth_mode_pin <= 1;
        sync_wait();
        bus(1, 8'h8C, 32'h0300_0000);
        bus(0, 8'h88, 32'h0000_0001);
        gate(1, 2'h1, 2'b10);
        ce <= 0;
        mem_req <= 1;
        repeat (3) @(posedge clk);
        chk({30'h0, mem_req_accept, mem_req_abort}, 32'h0000_0000);
        mem_req <= 0;
        @(posedge clk) ce <= 1;
        chk({31'h0, mc_accepting}, 32'h0000_0001);
        repeat (4) @(posedge clk);
        chk(rq.size() + gq.size(), 32'h0000_0000);
        final_report();
    end
endmodule : ccl_top_tb
